// >>> core/ssld_pkg.sv
package ssld_pkg;

  // ==========================================================
  // Word and latch layout
  localparam int SR_W = 24;
  typedef logic [SR_W-1:0] ssld_word_t;
  typedef logic [6:0][SR_W-1:0] ssld_latches_t;
  localparam ssld_word_t LATCH_RST = 24'h000000;

  localparam logic [2:0] LS_RF_N    = 3'h0;
  localparam logic [2:0] LS_RF_R    = 3'h1;
  localparam logic [2:0] LS_RF_CTRL = 3'h2;
  localparam logic [2:0] LS_MASTER  = 3'h3;
  localparam logic [2:0] LS_IF_N    = 3'h4;
  localparam logic [2:0] LS_IF_R    = 3'h5;
  localparam logic [2:0] LS_IF_CTRL = 3'h6;
  localparam logic [2:0] LS_NONE    = 3'h7;

  // ==========================================================
  // Field positions
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 3;
  localparam int RFN_RSV_BIT  = 23;
  localparam int RFN_INT_LSB  = 15;
  localparam int RFN_INT_W    = 8;
  localparam int RFN_FRAC_LSB = 3;
  localparam int RFN_FRAC_W   = 12;
  localparam int RFR_MOD_LSB  = 3;
  localparam int RFR_MOD_W    = 12;
  localparam int RFR_R_LSB    = 15;
  localparam int RFR_R_W      = 4;
  localparam int RFR_DBL_BIT  = 19;
  localparam int MST_MUX_LSB  = 7;
  localparam int MST_MUX_W    = 4;
  localparam int IFN_A_LSB    = 3;
  localparam int IFN_A_W      = 6;
  localparam int IFN_B_LSB    = 9;
  localparam int IFN_B_W      = 12;
  localparam int IFN_P_LSB    = 21;
  localparam int IFN_P_W      = 2;
  localparam int IFR_R_LSB    = 3;
  localparam int IFR_R_W      = 15;
  localparam int IFR_DBL_BIT  = 18;

  // Smallest prescaler modulus; code n selects this shifted by n
  localparam logic [6:0] PRESC_BASE = 7'h08;

  // ==========================================================
  // Output multiplexer codes
  localparam logic [3:0] MUX_TRISTATE = 4'h0;
  localparam logic [3:0] MUX_HIGH     = 4'h1;
  localparam logic [3:0] MUX_LOW      = 4'h2;
  localparam logic [3:0] MUX_RF_DLD   = 4'h3;
  localparam logic [3:0] MUX_IF_DLD   = 4'h4;
  localparam logic [3:0] MUX_RF_RDIV  = 4'h5;
  localparam logic [3:0] MUX_RF_NDIV  = 4'h6;
  localparam logic [3:0] MUX_IF_RDIV  = 4'h7;
  localparam logic [3:0] MUX_IF_NDIV  = 4'h8;
  localparam logic [3:0] MUX_RF_ALD   = 4'h9;
  localparam logic [3:0] MUX_IF_ALD   = 4'hA;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load;
  } ssld_serial_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ssld_pin_t;

endpackage

// >>> core/ssld_div.sv
`timescale 1ns/10ps
module ssld_div #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  output logic              pulse
);
  import ssld_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } ssld_div_st_t;

  ssld_div_st_t st_reg;
  ssld_div_st_t st_next;

  // Ratio zero behaves as divide by one rather than stalling
  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (tick) begin
      if (({1'b0, st_reg.cnt} + {{W{1'b0}}, 1'b1}) >= {1'b0, ratio}) begin
        st_next.cnt   = '0;
        st_next.pulse = 1'b1;
      end else begin
        st_next.cnt = W'(st_reg.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;

  div_restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_reg.pulse |-> (st_reg.cnt == '0 && $past(tick)))
    else $error("divider pulse without counter restart");

  div_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (ratio != '0 && $stable(ratio)) |=> (st_reg.cnt < ratio || $changed(ratio)))
    else $error("divider count ran past ratio");

endmodule

// >>> core/ssld_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Sample serial data on each serial clock rise
// - Words arrive MSB first, last bit lands bit0
// - Load strobe rise copies shift register to latch
// - Three low shifted bits choose the latch
// - Select codes map to seven named latches
// - RF integer value 8 bits, 31 to 255
// - Ratio is integer plus numerator over modulus
// - RF reference 4-bit divider, optional doubler
// - IF reference 15-bit divider, 1 to 32767
// - IF ratio is prescaler times main plus swallow
// - IF main count 12 bits, 3 to 4095
// - IF swallow count 6 bits, 0 to 63
// - Master mux bits pick the test output
// - Digital lock detect drives high when locked
// - Analog lock: released high with narrow low pulses when locked, held low when unlocked
// - RF feedback word field positions fixed
module ssld_top (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire ssld_pkg::ssld_serial_t serial_in,
  input  wire logic                   ref_in,
  input  wire logic                   rf_in,
  input  wire logic                   if_in,
  input  wire logic                   rf_lock,
  input  wire logic                   if_lock,
  output ssld_pkg::ssld_pin_t         test_mux_output,
  output ssld_pkg::ssld_latches_t     config_latches
);
  import ssld_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic          sclk_q;
    logic          load_q;
    logic          ref_q;
    logic          rf_q;
    logic          if_q;
    ssld_word_t    sr;
    ssld_latches_t lat;
    logic [8:0]    rf_cnt;
    logic [8:0]    rf_tgt;
    logic [11:0]   rf_acc;
    logic          rf_fb;
    logic [6:0]    if_pc;
    logic [11:0]   if_mc;
    logic [5:0]    if_sc;
    logic          if_fb;
    logic          mux_o;
    logic          mux_oe;
  } ssld_st_t;

  ssld_st_t st_reg;
  ssld_st_t st_next;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [6:0] presc_mod(input logic [1:0] code);
    return 7'(PRESC_BASE << code);
  endfunction

  // ==========================================================
  // Field decode
  logic                  sclk_rise;
  logic                  load_rise;
  logic                  ref_rise;
  logic                  ref_fall;
  logic                  rf_edge;
  logic                  if_edge;
  logic [RFN_INT_W-1:0]  int_val;
  logic [RFN_FRAC_W-1:0] frac_val;
  logic [RFR_MOD_W-1:0]  mod_val;
  logic [RFR_R_W-1:0]    rf_r_val;
  logic                  rf_dbl;
  logic [IFR_R_W-1:0]    if_r_val;
  logic                  if_dbl;
  logic [IFN_A_W-1:0]    a_val;
  logic [IFN_B_W-1:0]    b_val;
  logic [6:0]            p_val;
  logic [MST_MUX_W-1:0]  mux_sel;
  logic                  rf_ref_p;
  logic                  if_ref_p;
  logic                  rf_tick;
  logic                  if_tick;
  logic [SEL_W-1:0]      sel_now;

  assign sclk_rise = rise(serial_in.sclk, st_reg.sclk_q);
  assign load_rise = rise(serial_in.load, st_reg.load_q);
  assign ref_rise  = rise(ref_in, st_reg.ref_q);
  assign ref_fall  = rise(st_reg.ref_q, ref_in);
  assign rf_edge   = rise(rf_in, st_reg.rf_q);
  assign if_edge   = rise(if_in, st_reg.if_q);
  assign sel_now   = st_reg.sr[SEL_LSB +: SEL_W];

  // Reserved bit of the RF feedback word is stored but unused
  assign int_val  = st_reg.lat[LS_RF_N][RFN_INT_LSB +: RFN_INT_W];
  assign frac_val = st_reg.lat[LS_RF_N][RFN_FRAC_LSB +: RFN_FRAC_W];
  assign mod_val  = st_reg.lat[LS_RF_R][RFR_MOD_LSB +: RFR_MOD_W];
  assign rf_r_val = st_reg.lat[LS_RF_R][RFR_R_LSB +: RFR_R_W];
  assign rf_dbl   = st_reg.lat[LS_RF_R][RFR_DBL_BIT];
  assign if_r_val = st_reg.lat[LS_IF_R][IFR_R_LSB +: IFR_R_W];
  assign if_dbl   = st_reg.lat[LS_IF_R][IFR_DBL_BIT];
  assign a_val    = st_reg.lat[LS_IF_N][IFN_A_LSB +: IFN_A_W];
  assign b_val    = st_reg.lat[LS_IF_N][IFN_B_LSB +: IFN_B_W];
  assign p_val    = presc_mod(st_reg.lat[LS_IF_N][IFN_P_LSB +: IFN_P_W]);
  assign mux_sel  = st_reg.lat[LS_MASTER][MST_MUX_LSB +: MST_MUX_W];

  // Doubler counts both reference edges
  assign rf_tick = ref_rise | (rf_dbl & ref_fall);
  assign if_tick = ref_rise | (if_dbl & ref_fall);

  // ==========================================================
  // Reference dividers
  ssld_div #(.W(RFR_R_W)) u_rf_rdiv (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tick  (rf_tick),
    .ratio (rf_r_val),
    .pulse (rf_ref_p)
  );

  ssld_div #(.W(IFR_R_W)) u_if_rdiv (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tick  (if_tick),
    .ratio (if_r_val),
    .pulse (if_ref_p)
  );

  // ==========================================================
  // Next state
  logic [12:0] frac_sum;
  logic        swallow;
  logic [6:0]  pc_mod;

  assign frac_sum = {1'b0, st_reg.rf_acc} + {1'b0, frac_val};
  assign swallow  = st_reg.if_sc < a_val;
  assign pc_mod   = swallow ? 7'(p_val + 7'h01) : p_val;

  always_comb begin
    st_next = st_reg;
    st_next.sclk_q = serial_in.sclk;
    st_next.load_q = serial_in.load;
    st_next.ref_q  = ref_in;
    st_next.rf_q   = rf_in;
    st_next.if_q   = if_in;
    st_next.rf_fb  = 1'b0;
    st_next.if_fb  = 1'b0;

    // Serial shift; latches untouched until a strobe edge
    if (sclk_rise) begin
      st_next.sr = {st_reg.sr[SR_W-2:0], serial_in.sdata};
    end
    // Strobe and clock together: strobe takes the settled word
    if (load_rise && sel_now != LS_NONE) begin
      st_next.lat[sel_now] = st_reg.sr;
    end

    // RF feedback: first-order accumulator picks INT or INT+1
    if (rf_edge) begin
      if (9'(st_reg.rf_cnt + 9'h001) >= st_reg.rf_tgt) begin
        st_next.rf_cnt = 9'h000;
        st_next.rf_fb  = 1'b1;
        if (frac_sum >= {1'b0, mod_val}) begin
          st_next.rf_acc = 12'(frac_sum - {1'b0, mod_val});
          st_next.rf_tgt = 9'({1'b0, int_val} + 9'h001);
        end else begin
          st_next.rf_acc = frac_sum[11:0];
          st_next.rf_tgt = {1'b0, int_val};
        end
      end else begin
        st_next.rf_cnt = 9'(st_reg.rf_cnt + 9'h001);
      end
    end

    // IF pulse swallow: A prescaler cycles of P+1, then P
    if (if_edge) begin
      if (7'(st_reg.if_pc + 7'h01) >= pc_mod) begin
        st_next.if_pc = 7'h00;
        if (swallow) begin
          st_next.if_sc = 6'(st_reg.if_sc + 6'h01);
        end
        if (12'(st_reg.if_mc + 12'h001) >= b_val) begin
          st_next.if_mc = 12'h000;
          st_next.if_sc = 6'h00;
          st_next.if_fb = 1'b1;
        end else begin
          st_next.if_mc = 12'(st_reg.if_mc + 12'h001);
        end
      end else begin
        st_next.if_pc = 7'(st_reg.if_pc + 7'h01);
      end
    end

    // Output mux; analog lock is open drain, released means high
    unique case (mux_sel)
      MUX_HIGH: begin
        st_next.mux_o  = 1'b1;
        st_next.mux_oe = 1'b1;
      end
      MUX_LOW: begin
        st_next.mux_o  = 1'b0;
        st_next.mux_oe = 1'b1;
      end
      MUX_RF_DLD: begin
        st_next.mux_o  = rf_lock;
        st_next.mux_oe = 1'b1;
      end
      MUX_IF_DLD: begin
        st_next.mux_o  = if_lock;
        st_next.mux_oe = 1'b1;
      end
      MUX_RF_RDIV: begin
        st_next.mux_o  = rf_ref_p;
        st_next.mux_oe = 1'b1;
      end
      MUX_RF_NDIV: begin
        st_next.mux_o  = st_reg.rf_fb;
        st_next.mux_oe = 1'b1;
      end
      MUX_IF_RDIV: begin
        st_next.mux_o  = if_ref_p;
        st_next.mux_oe = 1'b1;
      end
      MUX_IF_NDIV: begin
        st_next.mux_o  = st_reg.if_fb;
        st_next.mux_oe = 1'b1;
      end
      MUX_RF_ALD: begin
        st_next.mux_o  = 1'b0;
        st_next.mux_oe = ~rf_lock | rf_ref_p;
      end
      MUX_IF_ALD: begin
        st_next.mux_o  = 1'b0;
        st_next.mux_oe = ~if_lock | if_ref_p;
      end
      default: begin
        st_next.mux_o  = 1'b0;
        st_next.mux_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // One driver for the whole pin struct
  assign test_mux_output = '{o: st_reg.mux_o, oe: st_reg.mux_oe};
  assign config_latches  = st_reg.lat;

  // ==========================================================
  // Checks
  shift_sample_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sclk_rise |=> st_reg.sr[0] == $past(serial_in.sdata))
    else $error("serial bit not sampled on clock rise");

  msb_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sclk_rise |=> st_reg.sr[SR_W-1:1] == $past(st_reg.sr[SR_W-2:0]))
    else $error("shift register did not move up one place");

  shift_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !sclk_rise |=> $stable(st_reg.sr))
    else $error("shift register changed without clock rise");

  latch_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (load_rise && sel_now != LS_NONE)
      |=> st_reg.lat[$past(sel_now)] == $past(st_reg.sr))
    else $error("selected latch not loaded on strobe");

  one_latch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (load_rise && sel_now == LS_RF_N)
      |=> st_reg.lat[LS_IF_CTRL:LS_RF_R] == $past(st_reg.lat[6:1]))
    else $error("strobe disturbed an unselected latch");

  bad_select_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (load_rise && sel_now == LS_NONE) |=> $stable(st_reg.lat))
    else $error("select code 111 changed a latch");

  latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !load_rise |=> $stable(st_reg.lat))
    else $error("latch changed without strobe");

  rf_ratio_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rf_edge && st_reg.rf_cnt == 9'(st_reg.rf_tgt - 9'h001)
      && $stable(st_reg.lat))
      |=> st_reg.rf_fb && (st_reg.rf_tgt == {1'b0, int_val}
        || st_reg.rf_tgt == 9'({1'b0, int_val} + 9'h001)))
    else $error("RF feedback modulus not INT or INT+1");

  if_cycle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_reg.if_fb |-> (st_reg.if_mc == 12'h000 && st_reg.if_sc == 6'h00
      && $past(if_edge)))
    else $error("IF feedback pulse without counter restart");

  mux_dld_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mux_sel == MUX_RF_DLD)
      |=> st_reg.mux_oe && st_reg.mux_o == $past(rf_lock))
    else $error("digital lock not driven high when locked");

  mux_ald_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mux_sel == MUX_RF_ALD && rf_lock && !rf_ref_p)
      |=> !st_reg.mux_oe ##0 !st_reg.mux_o)
    else $error("analog lock not released while locked");

  mux_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mux_sel == MUX_TRISTATE) |=> !st_reg.mux_oe)
    else $error("test output driven while three-stated");

endmodule

// >>> bench/ssld_host_model.sv
`timescale 1ns/10ps
module ssld_host_model (
  input  wire logic             mclk,
  output ssld_pkg::ssld_serial_t serial_out
);
  import ssld_pkg::*;

  initial begin
    serial_out = '0;
  end

  // ==========================================================
  // One frame: bits MSB first, two cycles low, two high
  task automatic send(input ssld_word_t w, input bit strobe);
    for (int i = SR_W - 1; i >= 0; i--) begin
      @(posedge mclk) #1;
      serial_out.sclk  = 1'b0;
      serial_out.sdata = w[i];
      @(posedge mclk) #1;
      @(posedge mclk) #1;
      serial_out.sclk = 1'b1;
      @(posedge mclk) #1;
    end
    @(posedge mclk) #1;
    serial_out.sclk = 1'b0;
    // Released line shows the inverse, not the last bit
    serial_out.sdata = ~w[0];
    @(posedge mclk) #1;
    serial_out.load = strobe;
    @(posedge mclk) #1;
    @(posedge mclk) #1;
    serial_out.load = 1'b0;
  endtask
endmodule

// >>> bench/test_synth_serial_load_and_dividers.sv
`timescale 1ns/10ps
module test_synth_serial_load_and_dividers;
  import ssld_pkg::*;

  logic          mclk;
  logic          rst_b;
  logic          ref_in;
  logic          rf_in;
  logic          if_in;
  logic          rf_lock;
  logic          if_lock;
  ssld_serial_t  serial_in;
  ssld_pin_t     pin;
  ssld_latches_t latches;
  ssld_latches_t shadow;
  int            failures;
  int            check_count;

  ssld_word_t div_w   [5] = '{24'h00002D, 24'h018011, 24'h098011,
                              24'h0F8008, 24'h00060C};
  logic [3:0] div_mux [5] = '{4'h7, 4'h5, 4'h5, 4'h6, 4'h8};
  int         div_in  [5] = '{0, 0, 0, 1, 2};
  int         div_ed  [5] = '{25, 30, 15, 63, 50};
  int         div_exp [5] = '{5, 10, 10, 2, 2};

  ssld_host_model host (
    .mclk       (mclk),
    .serial_out (serial_in)
  );

  ssld_top dut (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .serial_in       (serial_in),
    .ref_in          (ref_in),
    .rf_in           (rf_in),
    .if_in           (if_in),
    .rf_lock         (rf_lock),
    .if_lock         (if_lock),
    .test_mux_output (pin),
    .config_latches  (latches)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_all();
    for (int s = 0; s < 7; s++) begin
      check("latch", latches[s], shadow[s]);
    end
  endtask

  // ==========================================================
  // Access tasks
  task automatic write(input ssld_word_t w);
    host.send(w, 1'b1);
    repeat (3) @(posedge mclk);
    #1;
    if (w[2:0] != LS_NONE) begin
      shadow[w[2:0]] = w;
    end
  endtask

  task automatic mux_chk(input logic [3:0] c, input logic o,
                         input logic oe);
    write({13'h0000, c, 4'h0, LS_MASTER});
    repeat (2) @(posedge mclk);
    #1;
    check("mux oe", {23'h0, pin.oe}, {23'h0, oe});
    if (oe) begin
      check("mux o", {23'h0, pin.o}, {23'h0, o});
    end
  endtask

  // Toggles one input a given number of periods, counts pin rises
  task automatic count_div(input int sel, input int edges,
                           input int exp);
    int   n;
    logic prev;
    logic v;
    n = 0;
    prev = pin.o;
    for (int i = 0; i < edges * 8 + 40; i++) begin
      @(posedge mclk) #1;
      v = (i < edges * 8) && ((i % 8) < 4);
      case (sel)
        0: ref_in = v;
        1: rf_in = v;
        default: if_in = v;
      endcase
      if (pin.o === 1'b1 && prev === 1'b0) begin
        n++;
      end
      prev = pin.o;
    end
    check("divider pulses", n[23:0], exp[23:0]);
  endtask

  initial begin
    #100000;
    failures++;
    summarize();
  end

  initial begin
    failures = 0;
    check_count = 0;
    rst_b = 1'b0;
    ref_in = 1'b0;
    rf_in = 1'b0;
    if_in = 1'b0;
    rf_lock = 1'b1;
    if_lock = 1'b0;
    shadow = '0;
    repeat (16) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    check_all();
    check("reset oe", {23'h0, pin.oe}, 24'h0);
    for (int s = 0; s < 7; s++) begin
      write((24'h5A5A50 + s * 24'h111110) | s);
      check_all();
    end
    write(24'hFFFFFF);
    check_all();
    host.send(24'h123450, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    check_all();
    mux_chk(MUX_TRISTATE, 1'b0, 1'b0);
    mux_chk(MUX_HIGH, 1'b1, 1'b1);
    mux_chk(MUX_LOW, 1'b0, 1'b1);
    mux_chk(MUX_RF_DLD, 1'b1, 1'b1);
    mux_chk(MUX_IF_DLD, 1'b0, 1'b1);
    mux_chk(MUX_RF_ALD, 1'b0, 1'b0);
    mux_chk(MUX_IF_ALD, 1'b0, 1'b1);
    rf_lock = 1'b0;
    if_lock = 1'b1;
    mux_chk(MUX_RF_DLD, 1'b0, 1'b1);
    mux_chk(MUX_IF_DLD, 1'b1, 1'b1);
    mux_chk(MUX_RF_ALD, 1'b0, 1'b1);
    mux_chk(MUX_IF_ALD, 1'b0, 1'b0);
    mux_chk(4'hB, 1'b0, 1'b0);
    // Ratios: IF R 5, RF R 3, doubled, RF N 31.5, IF N 8*3+1
    for (int k = 0; k < 5; k++) begin
      write(div_w[k]);
      mux_chk(div_mux[k], 1'b0, 1'b1);
      count_div(div_in[k], div_ed[k], div_exp[k]);
    end
    check("int field", {16'h0, latches[0][22:15]}, 24'h00001F);
    check("frac field", {12'h0, latches[0][14:3]}, 24'h000001);
    check_all();
    summarize();
  end
endmodule
